// file: hdl/crf_flag_unit.sv
// Sixteen-bit adder that yields the sum, the carry out and two's complement overflow.
// Assumes purely combinational use by the register block on the same clock.
`timescale 1ns/1ps
`default_nettype none
module crf_flag_unit
    import crf_pkg::*;
#(
    parameter int WIDTH = CRF_W
) (
    // Operands.
    input  wire logic [WIDTH-1:0] a_in,
    input  wire logic [WIDTH-1:0] b_in,
    input  wire logic             sub_in,
    // Results.
    output logic      [WIDTH-1:0] sum_out,
    output logic                  carry_out,
    output logic                  ovf_out
);
    logic [WIDTH-1:0] b_eff;
    logic [WIDTH:0]   wide;

    // Subtraction adds the complement plus one, so carry means no borrow.
    always_comb begin
        b_eff     = sub_in ? ~b_in : b_in;
        wide      = {1'b0, a_in} + {1'b0, b_eff} + {{WIDTH{1'b0}}, sub_in};
        sum_out   = wide[WIDTH-1:0];
        carry_out = wide[WIDTH];
        // Overflow when both inputs share a sign that the sum lacks.
        ovf_out   = (a_in[WIDTH-1] == b_eff[WIDTH-1]) && (sum_out[WIDTH-1] != a_in[WIDTH-1]);
    end
endmodule
`default_nettype wire

// file: hdl/crf_register_block.sv
// General registers, program-visible flags, instruction decode and address formation.
// Assumes a sequencer that drives at most one step per cycle and answers indirect reads.
//
// Notes on behaviour
// RQ1: Eight general registers of sixteen bits each are held.
// RQ2: The address register is never readable or writable by program.
// RQ3: Extension register extends accumulator low-order and chains in double shifts.
// RQ4: Program counter advances or branches, and program may move it.
// RQ5: A subroutine jump places the return address in the link register.
// RQ6: Base adds before indirection, index adds after it.
// RQ7: Six flags exist: carry, dynamic, static and floating overflow, one-bit, shift link.
// RQ8: Carry is recomputed by every add, subtract, register, copy and add-to-register step.
// RQ9: Dynamic overflow is updated by those same instructions.
// RQ10: Static overflow sets on overflow except copy and stays until program clears.
// RQ11: Floating overflow sets on divide by zero and stays until cleared.
// RQ12: One-bit accumulator holds temporary results of the bit operation.
// RQ13: Shift link catches vacated bits so shifts chain.
// RQ14: Bit operation sets any flag; transfers move all flags with accumulator.
// RQ15: Opcode is the five top bits of the sixteen-bit instruction.
// RQ16: Bits eight, nine and ten are base, indirect and index modes.
// RQ17: Low eight bits are a sign-extended displacement, -128 to +127.
// RQ18: Single integers are one sixteen-bit two's complement word.
// RQ19: Double words load high half to accumulator, low half to extension.
// RQ20: Float is 32-bit mantissa, sign and biased 15-bit exponent.
// RQ21: Float spans three words addressed by the exponent word.
// RQ22: Float accumulator is extension, accumulator and temporary registers.
// RQ23: Non-copy overflow sets static overflow in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module crf_register_block
    import crf_pkg::*;
(
    // Clock and reset.
    input  wire logic             clock_in,
    input  wire logic             reset_in,
    // Program register access.
    input  wire logic             wr_en_in,
    input  wire logic [2:0]       wr_sel_in,
    input  wire logic [15:0]      wr_data_in,
    input  wire logic [2:0]       rd_sel_in,
    output logic      [15:0]      rd_data_out,
    // Instruction decode and address formation.
    input  wire logic             ea_start_in,
    input  wire logic [15:0]      instr_in,
    input  wire logic             mem_valid_in,
    input  wire logic [15:0]      mem_word_in,
    output logic      [4:0]       opcode_out,
    output logic      [2:0]       mode_out,
    output logic      [15:0]      disp_out,
    output logic      [15:0]      mem_addr_out,
    output logic                  mem_rd_out,
    output logic                  ea_done_out,
    // Sequencing.
    input  wire logic             pc_next_in,
    input  wire logic             pc_load_in,
    input  wire logic             jsub_in,
    input  wire logic [15:0]      pc_target_in,
    // Arithmetic.
    input  wire logic             arith_en_in,
    input  wire crf_arith_t       arith_cls_in,
    input  wire logic [2:0]       arith_dst_in,
    input  wire logic [15:0]      arith_a_in,
    input  wire logic [15:0]      arith_b_in,
    input  wire logic             fdiv_zero_in,
    // Flag operations and shifts.
    input  wire logic             bop_en_in,
    input  wire logic [2:0]       bop_idx_in,
    input  wire logic             bop_val_in,
    input  wire logic             tra_en_in,
    input  wire logic             trr_en_in,
    input  wire logic             shift_en_in,
    input  wire logic             shift_left_in,
    input  wire logic             shift_dbl_in,
    // Operand loads.
    input  wire logic             dload_en_in,
    input  wire logic             fload_en_in,
    input  wire logic [15:0]      load_exp_in,
    input  wire logic [15:0]      load_hi_in,
    input  wire logic [15:0]      load_lo_in,
    // Flag view.
    output logic      [5:0]       flags_out,
    output logic                  float_ovf_out
);
    typedef struct packed {
        logic [7:0][15:0] regs;
        logic [5:0]       flags;
        crf_ea_t          ea;
        logic             post_x;
        logic [15:0]      rd_data;
        logic [4:0]       opcode;
        logic [2:0]       mode;
        logic [15:0]      disp;
        logic             mem_rd;
        logic             ea_done;
    } crf_state_t;

    crf_state_t  s_r;
    crf_state_t  s_nxt;
    logic [15:0] sum;
    logic        carry;
    logic        ovf;
    logic        is_sub;
    logic        is_copy;

    // Sign-extends the low byte of an instruction word.
    function automatic logic [15:0] sext_disp(input logic [15:0] w);
        sext_disp = {{8{w[CRF_DISP_MSB]}}, w[CRF_DISP_MSB:0]};
    endfunction

    // Program register select: slot 0 stands for the zero register, never the address register.
    function automatic logic prog_slot(input logic [2:0] sel);
        prog_slot = (sel != CRF_SLOT_R);
    endfunction

    // Copy adds its source to zero so carry and overflow still get fresh values.
    assign is_sub  = (arith_cls_in == CRF_AR_SUB) || (arith_cls_in == CRF_AR_REGISTER_SUBTRACT_INSTR);
    assign is_copy = (arith_cls_in == CRF_AR_COPY);

    crf_flag_unit #(.WIDTH(CRF_W)) u_add (
        .a_in      (is_copy ? CRF_REG_RST : arith_a_in),
        .b_in      (arith_b_in),
        .sub_in    (is_sub),
        .sum_out   (sum),
        .carry_out (carry),
        .ovf_out   (ovf)
    );

    // Next-state logic; later steps in this process take priority over earlier ones.
    always_comb begin
        logic [15:0] base;
        logic [15:0] pre;
        // Instruction decode and address formation; base goes in before indirection.
        base = s_r.regs[CRF_SLOT_P];
        if (instr_in[CRF_BIT_B]) begin
            base = s_r.regs[CRF_SLOT_B]; // RQ6
        end else if (instr_in[CRF_BIT_X] && !instr_in[CRF_BIT_I]) begin
            base = s_r.regs[CRF_SLOT_X]; // RQ16
        end
        pre = base + sext_disp(instr_in); // RQ17
        s_nxt         = s_r;
        s_nxt.ea_done = 1'b0;
        // Reads of slot 0 give zero so the address register stays hidden.
        s_nxt.rd_data = prog_slot(rd_sel_in) ? s_r.regs[rd_sel_in] : CRF_REG_RST; // RQ2
        if (wr_en_in && prog_slot(wr_sel_in)) begin
            s_nxt.regs[wr_sel_in] = wr_data_in; // RQ1
        end
        // Program counter: step, branch, or subroutine jump with link.
        if (pc_next_in) begin
            s_nxt.regs[CRF_SLOT_P] = s_r.regs[CRF_SLOT_P] + 16'h0001; // RQ4
        end
        if (pc_load_in || jsub_in) begin
            s_nxt.regs[CRF_SLOT_P] = pc_target_in; // RQ4
        end
        if (jsub_in) begin
            s_nxt.regs[CRF_SLOT_L] = s_r.regs[CRF_SLOT_P] + 16'h0001; // RQ5
        end
        // Program flag writes go first so that hardware sets below win a same-cycle clear.
        if (trr_en_in) begin
            s_nxt.flags = s_r.regs[CRF_SLOT_A][CRF_NFLAGS-1:0]; // RQ14
        end
        if (bop_en_in && (bop_idx_in < 3'h6)) begin
            s_nxt.flags[bop_idx_in] = bop_val_in; // RQ12 RQ14
        end
        if (tra_en_in) begin
            s_nxt.regs[CRF_SLOT_A] = {10'h000, s_r.flags}; // RQ14
        end
        // Shifts pass the vacated bit to the shift link and bring the old link in.
        if (shift_en_in) begin
            if (shift_left_in && shift_dbl_in) begin
                {s_nxt.flags[CRF_FLG_M], s_nxt.regs[CRF_SLOT_A], s_nxt.regs[CRF_SLOT_D]} =
                    {s_r.regs[CRF_SLOT_A], s_r.regs[CRF_SLOT_D], s_r.flags[CRF_FLG_M]}; // RQ3 RQ13
            end else if (shift_left_in) begin
                {s_nxt.flags[CRF_FLG_M], s_nxt.regs[CRF_SLOT_A]} =
                    {s_r.regs[CRF_SLOT_A], s_r.flags[CRF_FLG_M]}; // RQ13
            end else if (shift_dbl_in) begin
                {s_nxt.regs[CRF_SLOT_A], s_nxt.regs[CRF_SLOT_D], s_nxt.flags[CRF_FLG_M]} =
                    {s_r.flags[CRF_FLG_M], s_r.regs[CRF_SLOT_A], s_r.regs[CRF_SLOT_D]}; // RQ3 RQ13
            end else begin
                {s_nxt.regs[CRF_SLOT_A], s_nxt.flags[CRF_FLG_M]} =
                    {s_r.flags[CRF_FLG_M], s_r.regs[CRF_SLOT_A]}; // RQ13
            end
        end
        // Operand loads: high half into the accumulator, low into the extension.
        if (dload_en_in || fload_en_in) begin
            s_nxt.regs[CRF_SLOT_A] = load_hi_in; // RQ19 RQ22
            s_nxt.regs[CRF_SLOT_D] = load_lo_in; // RQ3 RQ19 RQ22
        end
        if (fload_en_in) begin
            s_nxt.regs[CRF_SLOT_T] = load_exp_in; // RQ20 RQ21 RQ22
        end
        // Arithmetic writes its result and refreshes carry and dynamic overflow.
        if (arith_en_in) begin
            if (prog_slot(arith_dst_in)) begin
                s_nxt.regs[arith_dst_in] = sum; // RQ18
            end
            s_nxt.flags[CRF_FLG_C] = carry; // RQ8
            s_nxt.flags[CRF_FLG_O] = ovf; // RQ9
            if (ovf && !is_copy) begin
                s_nxt.flags[CRF_FLG_Q] = 1'b1; // RQ10 RQ23
            end
        end
        if (fdiv_zero_in) begin
            s_nxt.flags[CRF_FLG_Z] = 1'b1; // RQ11
        end
        case (s_r.ea)
            CRF_EA_IDLE: begin
                if (ea_start_in) begin
                    s_nxt.opcode = instr_in[CRF_OPC_MSB:CRF_OPC_LSB]; // RQ15
                    s_nxt.mode   = instr_in[CRF_BIT_X:CRF_BIT_B]; // RQ16
                    s_nxt.disp   = sext_disp(instr_in); // RQ17
                    s_nxt.post_x = instr_in[CRF_BIT_X] && instr_in[CRF_BIT_I];
                    if (instr_in[CRF_BIT_I]) begin
                        s_nxt.regs[CRF_SLOT_R] = pre;
                        s_nxt.mem_rd           = 1'b1;
                        s_nxt.ea               = CRF_EA_WAIT;
                    end else begin
                        s_nxt.regs[CRF_SLOT_R] = pre + ((instr_in[CRF_BIT_X] && instr_in[CRF_BIT_B]) ?
                                                        s_r.regs[CRF_SLOT_X] : CRF_REG_RST);
                        s_nxt.ea_done          = 1'b1;
                    end
                end
            end
            CRF_EA_WAIT: begin
                // Index goes in after the indirect word returns.
                if (mem_valid_in) begin
                    s_nxt.regs[CRF_SLOT_R] = mem_word_in + (s_r.post_x ? s_r.regs[CRF_SLOT_X] : CRF_REG_RST); // RQ6
                    s_nxt.mem_rd           = 1'b0;
                    s_nxt.ea_done          = 1'b1;
                    s_nxt.ea               = CRF_EA_IDLE;
                end
            end
            default: begin
                s_nxt.ea     = CRF_EA_IDLE;
                s_nxt.mem_rd = 1'b0;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            s_r         <= '0;
            s_r.flags   <= CRF_FLG_RST;
            s_r.ea      <= CRF_EA_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign rd_data_out   = s_r.rd_data;
    assign opcode_out    = s_r.opcode;
    assign mode_out      = s_r.mode;
    assign disp_out      = s_r.disp;
    assign mem_addr_out  = s_r.regs[CRF_SLOT_R];
    assign mem_rd_out    = s_r.mem_rd;
    assign ea_done_out   = s_r.ea_done;
    assign flags_out     = s_r.flags; // RQ7
    assign float_ovf_out = s_r.flags[CRF_FLG_Z];

    // Checks; helper terms keep the conditions short.
    wire logic quiet = !wr_en_in && !pc_load_in && !jsub_in && !shift_en_in && !trr_en_in && !bop_en_in;

    AST_ZERO_SLOT: assert property (@(posedge clock_in) disable iff (reset_in) // RQ2
        rd_sel_in == CRF_SLOT_R |=> rd_data_out == 16'h0000) else $error("Hidden slot was readable");
    AST_LINK: assert property (@(posedge clock_in) disable iff (reset_in) // RQ5
        jsub_in && !arith_en_in |=> s_r.regs[CRF_SLOT_L] == $past(s_r.regs[CRF_SLOT_P]) + 16'h0001
        && s_r.regs[CRF_SLOT_P] == $past(pc_target_in)) else $error("Link or target wrong");
    AST_PC_STEP: assert property (@(posedge clock_in) disable iff (reset_in) // RQ4
        pc_next_in && quiet && !arith_en_in |=> s_r.regs[CRF_SLOT_P] == $past(s_r.regs[CRF_SLOT_P]) + 16'h0001)
        else $error("Program counter did not step");
    AST_Q_STICKY: assert property (@(posedge clock_in) disable iff (reset_in) // RQ10
        s_r.flags[CRF_FLG_Q] && quiet |=> s_r.flags[CRF_FLG_Q]) else $error("Static overflow dropped");
    AST_Q_ON_OVF: assert property (@(posedge clock_in) disable iff (reset_in) // RQ23
        arith_en_in && ovf && !is_copy |=> s_r.flags[CRF_FLG_Q] && s_r.flags[CRF_FLG_O])
        else $error("Overflow did not set both flags");
    AST_COPY_NO_Q: assert property (@(posedge clock_in) disable iff (reset_in) // RQ10
        arith_en_in && is_copy && !s_r.flags[CRF_FLG_Q] && quiet |=> !s_r.flags[CRF_FLG_Q])
        else $error("Copy set static overflow");
    AST_CARRY: assert property (@(posedge clock_in) disable iff (reset_in) // RQ8
        arith_en_in && !shift_en_in |=> s_r.flags[CRF_FLG_C] == $past(carry)) else $error("Carry stale");
    AST_FDIV: assert property (@(posedge clock_in) disable iff (reset_in) // RQ11
        fdiv_zero_in |=> float_ovf_out && flags_out[CRF_FLG_Z]) else $error("Float overflow missed");
    AST_SHIFT_LINK: assert property (@(posedge clock_in) disable iff (reset_in) // RQ13
        shift_en_in && shift_left_in && !shift_dbl_in && !arith_en_in && !bop_en_in && !trr_en_in
        |=> s_r.flags[CRF_FLG_M] == $past(s_r.regs[CRF_SLOT_A][15])) else $error("Shift link wrong");
    AST_DLOAD: assert property (@(posedge clock_in) disable iff (reset_in) // RQ19
        dload_en_in && !arith_en_in |=> s_r.regs[CRF_SLOT_A] == $past(load_hi_in)
        && s_r.regs[CRF_SLOT_D] == $past(load_lo_in)) else $error("Double load misplaced");
    AST_EA_DIRECT: assert property (@(posedge clock_in) disable iff (reset_in) // RQ17
        ea_start_in && s_r.ea == CRF_EA_IDLE && instr_in[10:8] == 3'h0 |=> ea_done_out
        && mem_addr_out == $past(s_r.regs[CRF_SLOT_P]) + disp_out) else $error("Relative address wrong");
    AST_INDIR_BOUND: assert property (@(posedge clock_in) disable iff (reset_in) // RQ6
        s_r.ea == CRF_EA_WAIT && mem_valid_in |=> ea_done_out && !mem_rd_out) else $error("Indirect not closed");

    COV_INDIRECT: cover property (@(posedge clock_in) disable iff (reset_in) s_r.ea == CRF_EA_WAIT ##1 ea_done_out);
    COV_STATIC: cover property (@(posedge clock_in) disable iff (reset_in) arith_en_in && ovf && !is_copy);
    COV_JSUB: cover property (@(posedge clock_in) disable iff (reset_in) jsub_in);
    COV_DSHIFT: cover property (@(posedge clock_in) disable iff (reset_in) shift_en_in && shift_dbl_in);
endmodule
`default_nettype wire

// file: inc/crf_pkg.sv
// Shared constants for the processor register and flag block.
// Assumes a single 20 MHz clock domain and one operation step per cycle.
package crf_pkg;
    // Word width.
    localparam int          CRF_W        = 16;
    // Register slot numbers; slot 0 holds the address register, which program selects read as zero.
    localparam logic [2:0]  CRF_SLOT_R   = 3'h0;
    localparam logic [2:0]  CRF_SLOT_D   = 3'h1;
    localparam logic [2:0]  CRF_SLOT_P   = 3'h2;
    localparam logic [2:0]  CRF_SLOT_B   = 3'h3;
    localparam logic [2:0]  CRF_SLOT_L   = 3'h4;
    localparam logic [2:0]  CRF_SLOT_A   = 3'h5;
    localparam logic [2:0]  CRF_SLOT_T   = 3'h6;
    localparam logic [2:0]  CRF_SLOT_X   = 3'h7;
    // Flag bit positions, also their positions in the accumulator on group transfer.
    localparam int          CRF_FLG_C    = 0;
    localparam int          CRF_FLG_O    = 1;
    localparam int          CRF_FLG_Q    = 2;
    localparam int          CRF_FLG_Z    = 3;
    localparam int          CRF_FLG_K    = 4;
    localparam int          CRF_FLG_M    = 5;
    localparam int          CRF_NFLAGS   = 6;
    // Instruction word fields.
    localparam int          CRF_OPC_MSB  = 15;
    localparam int          CRF_OPC_LSB  = 11;
    localparam int          CRF_BIT_X    = 10;
    localparam int          CRF_BIT_I    = 9;
    localparam int          CRF_BIT_B    = 8;
    localparam int          CRF_DISP_MSB = 7;
    // Reset values.
    localparam logic [15:0] CRF_REG_RST  = 16'h0000;
    localparam logic [5:0]  CRF_FLG_RST  = 6'h00;
    // Arithmetic instruction classes that touch carry and overflow.
    typedef enum logic [2:0] {
        CRF_AR_ADD, CRF_AR_SUB, CRF_AR_REGISTER_ADD_INSTR, CRF_AR_REGISTER_SUBTRACT_INSTR, CRF_AR_COPY, CRF_AR_ADDREG
    } crf_arith_t;
    // Effective address sequencer states.
    typedef enum logic [0:0] {
        CRF_EA_IDLE, CRF_EA_WAIT
    } crf_ea_t;
endpackage

// file: sim/crf_mem_model.sv
// Memory model standing behind the block's indirect word read port.
// Assumes the block holds its read request and pointer until the word is taken.
`timescale 1ns/1ps
`default_nettype none
module crf_mem_model
    import crf_pkg::*;
(
    // Clock, reset and request.
    input  wire logic          clock_in,
    input  wire logic          reset_in,
    input  wire logic          mem_rd_in,
    input  wire logic [15:0]   mem_addr_in,
    input  wire logic [3:0]    delay_in,
    // Answer.
    output logic               mem_valid_out,
    output logic      [15:0]   mem_word_out
);
    logic [3:0] wait_r;

    // The word is the pointer with a fixed pattern folded in, so the bench can predict it.
    // Outside the valid cycle the word turns to the inverse of its last value, never a stale copy.
    always @(posedge clock_in) begin
        if (reset_in) begin
            mem_valid_out <= 1'b0;
            mem_word_out  <= 16'hffff;
            wait_r        <= 4'h0;
        end else if (mem_valid_out) begin
            mem_valid_out <= 1'b0;
            mem_word_out  <= ~mem_word_out;
            wait_r        <= 4'h0;
        end else if (mem_rd_in && wait_r == delay_in) begin
            mem_valid_out <= 1'b1;
            mem_word_out  <= mem_addr_in ^ 16'h3c3c;
        end else if (mem_rd_in) begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the register and flag block with its memory model.
// Assumes inputs change at the falling edge and outputs are read there too.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import crf_pkg::*;
;
    logic        clock_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        wr_en, ea_start, pc_next, pc_load, jsub, arith_en, fdiv, bop_en, bop_val;
    logic        tra_en, trr_en, sh_en, sh_left, sh_dbl, dld, fld, mem_valid, mem_rd, ea_done, fovf;
    logic [2:0]  wr_sel, rd_sel, dst, bop_idx, mode;
    logic [4:0]  opcode;
    logic [5:0]  flags;
    logic [3:0]  delay;
    logic [15:0] wr_data, instr, mem_word, target, op_a, op_b, ld_exp, ld_hi, ld_lo, rd_data, disp, mem_addr;
    crf_arith_t  cls;
    int          err_total = 0;
    int          checked = 0;

    // Clock at 20 MHz.
    always #25 clock_in = ~clock_in;

    crf_register_block i_crf_register_block (.clock_in(clock_in), .reset_in(reset_in), .wr_en_in(wr_en),
        .wr_sel_in(wr_sel), .wr_data_in(wr_data), .rd_sel_in(rd_sel), .rd_data_out(rd_data),
        .ea_start_in(ea_start), .instr_in(instr), .mem_valid_in(mem_valid), .mem_word_in(mem_word),
        .opcode_out(opcode), .mode_out(mode), .disp_out(disp), .mem_addr_out(mem_addr), .mem_rd_out(mem_rd),
        .ea_done_out(ea_done), .pc_next_in(pc_next), .pc_load_in(pc_load), .jsub_in(jsub),
        .pc_target_in(target), .arith_en_in(arith_en), .arith_cls_in(cls), .arith_dst_in(dst),
        .arith_a_in(op_a), .arith_b_in(op_b), .fdiv_zero_in(fdiv), .bop_en_in(bop_en), .bop_idx_in(bop_idx),
        .bop_val_in(bop_val), .tra_en_in(tra_en), .trr_en_in(trr_en), .shift_en_in(sh_en),
        .shift_left_in(sh_left), .shift_dbl_in(sh_dbl), .dload_en_in(dld), .fload_en_in(fld),
        .load_exp_in(ld_exp), .load_hi_in(ld_hi), .load_lo_in(ld_lo), .flags_out(flags),
        .float_ovf_out(fovf));

    crf_mem_model i_crf_mem_model (.clock_in(clock_in), .reset_in(reset_in), .mem_rd_in(mem_rd),
        .mem_addr_in(mem_addr), .delay_in(delay), .mem_valid_out(mem_valid), .mem_word_out(mem_word));

    // Every strobe is a one-cycle pulse, so all of them drop together one cycle after they rise.
    task automatic tick();
        @(negedge clock_in);
        {wr_en, ea_start, pc_next, pc_load, jsub, arith_en, fdiv, bop_en, tra_en, trr_en, sh_en, dld, fld} = '0;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_flags(input logic [5:0] got, input logic [5:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: flags got %h want %h", $time, got, exp);
        end
    endtask

    // The read answer lands at the edge that samples the select, and is checked one cycle after the select is set.
    task automatic rd(input logic [2:0] s, input logic [15:0] e);
        @(negedge clock_in);
        rd_sel = s;
        @(negedge clock_in);
        chk_word(rd_data, e, "read");
    endtask

    task automatic wr(input logic [2:0] s, input logic [15:0] d);
        @(negedge clock_in);
        {wr_en, wr_sel, wr_data} = {1'b1, s, d};
        tick();
    endtask

    task automatic ar(input crf_arith_t c, input logic [2:0] d, input logic [15:0] a, input logic [15:0] b);
        @(negedge clock_in);
        {arith_en, cls, dst, op_a, op_b} = {1'b1, c, d, a, b};
        tick();
    endtask

    // One step on the sequencing, flag or shift strobes; idx picks which strobe.
    task automatic op(input int idx, input logic [2:0] v, input logic b, input logic [15:0] t);
        @(negedge clock_in);
        {bop_idx, bop_val, sh_left, sh_dbl, target} = {v, b, v[0], v[1], t};
        case (idx)
            0: pc_load = 1'b1;
            1: pc_next = 1'b1;
            2: jsub = 1'b1;
            3: bop_en = 1'b1;
            4: tra_en = 1'b1;
            5: trr_en = 1'b1;
            6: sh_en = 1'b1;
            default: fdiv = 1'b1;
        endcase
        tick();
    endtask

    // Address formation; a slow memory answer is chosen through the delay argument.
    task automatic ea(input logic [15:0] ins, input logic [15:0] pre, input logic [15:0] fin, input logic [3:0] dl);
        int n = 0;
        @(negedge clock_in);
        {ea_start, instr, delay} = {1'b1, ins, dl};
        tick();
        chk_word({8'h00, opcode, mode}, {8'h00, ins[15:8]}, "opcode and mode");
        chk_word(disp, {{8{ins[7]}}, ins[7:0]}, "displacement");
        if (ins[9]) begin
            chk_word({mem_rd, 15'h0000} ^ mem_addr, {1'b1, 15'h0000} ^ pre, "pointer");
        end
        while (ea_done !== 1'b1 && n < 20) begin
            @(negedge clock_in);
            n++;
        end
        chk_word({ea_done, mem_rd, 14'h0000} ^ mem_addr, {2'b10, 14'h0000} ^ fin, "effective address");
    endtask

    task automatic report_and_stop();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // A run takes a few hundred cycles, so this limit only trips on a hang.
    initial begin
        repeat (5000) @(posedge clock_in);
        err_total++;
        report_and_stop();
    end

    initial begin
        {wr_sel, rd_sel, dst, bop_idx, bop_val, sh_left, sh_dbl, delay} = '0;
        {wr_data, instr, target, op_a, op_b, ld_exp, ld_hi, ld_lo} = '0;
        cls = CRF_AR_ADD;
        repeat (8) tick();
        reset_in = 1'b0;
        for (int s = 0; s < 8; s++) rd(3'(s), 16'h0000);
        chk_flags(flags, 6'h00);
        for (int s = 1; s < 8; s++) wr(3'(s), 16'(s * 16'h1111));
        for (int s = 1; s < 8; s++) rd(3'(s), 16'(s * 16'h1111));
        wr(CRF_SLOT_R, 16'hbeef);
        rd(CRF_SLOT_R, 16'h0000);
        op(0, 3'h0, 1'b0, 16'h0100);
        op(1, 3'h0, 1'b0, 16'h0000);
        rd(CRF_SLOT_P, 16'h0101);
        op(2, 3'h0, 1'b0, 16'h0200);
        rd(CRF_SLOT_L, 16'h0102);
        rd(CRF_SLOT_P, 16'h0200);
        // Arithmetic flag updates, including copy leaving static overflow alone.
        ar(CRF_AR_ADD, CRF_SLOT_A, 16'h7fff, 16'h0001);
        rd(CRF_SLOT_A, 16'h8000);
        chk_flags(flags, 6'h06);
        ar(CRF_AR_COPY, CRF_SLOT_T, 16'h1234, 16'h0001);
        rd(CRF_SLOT_T, 16'h0001);
        chk_flags(flags, 6'h04);
        op(3, 3'h2, 1'b0, 16'h0000);
        ar(CRF_AR_COPY, CRF_SLOT_T, 16'h0000, 16'h8000);
        chk_flags(flags, 6'h00);
        ar(CRF_AR_REGISTER_ADD_INSTR, CRF_SLOT_X, 16'hffff, 16'h0001);
        chk_flags(flags, 6'h01);
        ar(CRF_AR_ADDREG, CRF_SLOT_B, 16'h8000, 16'h8000);
        chk_flags(flags, 6'h07);
        wr(CRF_SLOT_A, 16'h0000);
        op(5, 3'h0, 1'b0, 16'h0000);
        ar(CRF_AR_SUB, CRF_SLOT_D, 16'h8000, 16'h0001);
        rd(CRF_SLOT_D, 16'h7fff);
        chk_flags(flags & 6'h3e, 6'h06);
        ar(CRF_AR_REGISTER_SUBTRACT_INSTR, CRF_SLOT_L, 16'h0005, 16'h0003);
        rd(CRF_SLOT_L, 16'h0002);
        chk_flags(flags & 6'h3e, 6'h04);
        // Floating overflow holds until program clears it.
        op(7, 3'h0, 1'b0, 16'h0000);
        repeat (3) @(negedge clock_in);
        chk_flags({fovf, flags[4:0]} & 6'h28, 6'h28);
        op(3, 3'h3, 1'b0, 16'h0000);
        chk_flags({5'h00, fovf}, 6'h00);
        for (int i = 0; i < 6; i++) op(3, 3'(i), 1'b1, 16'h0000);
        chk_flags(flags, 6'h3f);
        op(4, 3'h0, 1'b0, 16'h0000);
        rd(CRF_SLOT_A, 16'h003f);
        wr(CRF_SLOT_A, 16'h0015);
        op(5, 3'h0, 1'b0, 16'h0000);
        chk_flags(flags, 6'h15);
        // Shifts through the shift link, single and chained.
        wr(CRF_SLOT_A, 16'h8001);
        op(3, 3'h5, 1'b0, 16'h0000);
        op(6, 3'h1, 1'b0, 16'h0000);
        rd(CRF_SLOT_A, 16'h0002);
        chk_flags(flags & 6'h20, 6'h20);
        op(6, 3'h1, 1'b0, 16'h0000);
        rd(CRF_SLOT_A, 16'h0005);
        op(6, 3'h0, 1'b0, 16'h0000);
        rd(CRF_SLOT_A, 16'h0002);
        chk_flags(flags & 6'h20, 6'h20);
        wr(CRF_SLOT_A, 16'h0000);
        wr(CRF_SLOT_D, 16'h8000);
        op(6, 3'h3, 1'b0, 16'h0000);
        rd(CRF_SLOT_A, 16'h0001);
        rd(CRF_SLOT_D, 16'h0001);
        op(6, 3'h2, 1'b0, 16'h0000);
        rd(CRF_SLOT_D, 16'h8000);
        chk_flags(flags & 6'h20, 6'h20);
        // Double and floating operand loads.
        @(negedge clock_in);
        {dld, ld_hi, ld_lo} = {1'b1, 16'h1234, 16'h5678};
        tick();
        rd(CRF_SLOT_A, 16'h1234);
        rd(CRF_SLOT_D, 16'h5678);
        @(negedge clock_in);
        {fld, ld_exp, ld_hi, ld_lo} = {1'b1, 16'h4001, 16'h8000, 16'h0001};
        tick();
        rd(CRF_SLOT_T, 16'h4001);
        rd(CRF_SLOT_A, 16'h8000);
        rd(CRF_SLOT_D, 16'h0001);
        // Effective addresses in six of the eight modes, all but 3'b011 and 3'b110, with prompt and slow memory.
        op(0, 3'h0, 1'b0, 16'h0100);
        wr(CRF_SLOT_B, 16'h1000);
        wr(CRF_SLOT_X, 16'h0030);
        ea(16'hf880, 16'h0000, 16'h0080, 4'h0);
        ea(16'h097f, 16'h0000, 16'h107f, 4'h0);
        ea(16'h1410, 16'h0000, 16'h0040, 4'h0);
        ea(16'h1d01, 16'h0000, 16'h1031, 4'h0);
        ea(16'h27fe, 16'h0ffe, 16'h33f2, 4'h0);
        ea(16'h2a05, 16'h0105, 16'h3d39, 4'h3);
        report_and_stop();
    end
endmodule
`default_nettype wire
